// >>> hw/iabi_pkg.sv
package iabi_pkg;

  // internal clock and cycle layout, in divided ticks
  localparam int unsigned DIV_RATIO        = 4;
  localparam int unsigned CYCLE_TICKS      = 1280;
  localparam int unsigned ZERO_TICKS       = 246;
  localparam int unsigned INTEG_TICKS      = 256;
  localparam int unsigned DEINT_TICKS      = 778;
  localparam int unsigned BUSY_TICKS       = 836;
  localparam int unsigned DEMAND_TO_BUSY   = 1155;
  localparam int unsigned LOCKOUT_TICKS    = 1100;
  // result valid window after busy falls, in half ticks (443-1/2 ticks)
  localparam int unsigned VALID_HALF_TICKS = 887;

  // deintegrate subphase limits
  localparam int unsigned FAST_MAX   = 512;
  localparam int unsigned SLOW_MAX   = 64;
  localparam int unsigned OVR_MAX    = 192;
  localparam int unsigned MAX_EXCESS = 190;

  // cycle positions, lockout load and subphase count limits derived from the figures above
  localparam logic [10:0] POS_LAST      = 11'(CYCLE_TICKS - 1);
  localparam logic [10:0] POS_INTEG     = 11'(ZERO_TICKS);
  localparam logic [10:0] POS_DEINT     = 11'(ZERO_TICKS + INTEG_TICKS);
  localparam logic [10:0] POS_BUSY_RISE = 11'(CYCLE_TICKS - BUSY_TICKS);
  localparam logic [10:0] POS_IDLE      = 11'(CYCLE_TICKS - DEMAND_TO_BUSY);
  localparam logic [10:0] POS_DISCARD   = 11'(VALID_HALF_TICKS / 2);
  localparam logic [10:0] LOCKOUT_INIT  = 11'(LOCKOUT_TICKS);
  localparam logic [8:0]  FAST_LAST     = 9'(FAST_MAX - 1);
  localparam logic [5:0]  SLOW_LAST     = 6'(SLOW_MAX - 1);
  localparam logic [7:0]  OVR_LAST      = 8'(OVR_MAX - 1);
  localparam logic [7:0]  EXCESS_CAP    = 8'(MAX_EXCESS);

  // bit positions of the synchronised pin bundle
  localparam int unsigned PIN_W     = 7;
  localparam int unsigned PIN_CE_N  = 6;
  localparam int unsigned PIN_CS    = 5;
  localparam int unsigned PIN_RD_N  = 4;
  localparam int unsigned PIN_WR_N  = 3;
  localparam int unsigned PIN_BSEL  = 2;
  localparam int unsigned PIN_SOSEL = 1;
  localparam int unsigned PIN_MODE  = 0;
  // idle pin levels: deselected, strobes high, on-demand mode
  localparam logic [6:0]  PIN_IDLE  = 7'h58;

  // continuous-mode read sequence
  localparam logic [1:0] SEQ_HIGH_POL = 2'h0;
  localparam logic [1:0] SEQ_LOW      = 2'h1;
  localparam logic [1:0] SEQ_HIGH_OVR = 2'h2;

  // deintegrate subphase states, one-hot
  typedef enum logic [4:0] {
    SP_IDLE = 5'h01,
    SP_FAST = 5'h02,
    SP_SLOW = 5'h04,
    SP_OVR  = 5'h08,
    SP_DONE = 5'h10
  } iabi_sub_e;

endpackage

// >>> hw/iabi_rd_if.sv
`timescale 1ns/1ns
// carries the latched result and bus strobes between the top and the read mux
interface iabi_rd_if;
  logic        rd_active;
  logic        rd_rise;
  logic        cont_mode;
  logic        byte_sel;
  logic        sign_sel;
  logic        new_result;
  logic        discard;
  logic [14:0] mag;
  logic        positive;
  logic        overrange;
  logic [7:0]  data;
  logic        oe;

  modport ctl (
    output rd_active, rd_rise, cont_mode, byte_sel, sign_sel, new_result, discard,
    output mag, positive, overrange,
    input  data, oe
  );
  modport mux (
    input  rd_active, rd_rise, cont_mode, byte_sel, sign_sel, new_result, discard,
    input  mag, positive, overrange,
    output data, oe
  );
endinterface

// >>> hw/iabi_pin_sync.sv
`timescale 1ns/1ns
// three-stage synchroniser; output follows only once stages two and three agree
module iabi_pin_sync #(
  parameter int unsigned      WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  if (WIDTH < 1) begin : g_bad
    $error("iabi_pin_sync needs a width of at least one");
  end

  // stage one is read by stage two only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per-bit agreement filter, rejects a single-cycle disagreement
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_out <= INIT;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// >>> hw/iabi_read_mux.sv
`timescale 1ns/1ns
// byte selection, continuous-mode byte counter and registered bus drive
module iabi_read_mux (
  input  wire logic clock,
  input  wire logic rst,
  iabi_rd_if.mux    rd
);
  logic [1:0] seq_q;
  logic [7:0] byte_d;
  logic       high_sel;
  logic       top_sel_ovr;

  // byte counter restarts with each new result or discard
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seq_q <= iabi_pkg::SEQ_HIGH_POL;
    end else if (rd.new_result || rd.discard) begin
      seq_q <= iabi_pkg::SEQ_HIGH_POL;
    end else if (rd.cont_mode && rd.rd_rise) begin
      seq_q <= (seq_q == iabi_pkg::SEQ_HIGH_OVR) ? iabi_pkg::SEQ_HIGH_POL : 2'(seq_q + 2'h1);
    end
  end

  // selects only matter in on-demand mode; sign select only on high-byte reads
  always_comb begin
    if (rd.cont_mode) begin
      high_sel    = (seq_q != iabi_pkg::SEQ_LOW);
      top_sel_ovr = (seq_q == iabi_pkg::SEQ_HIGH_OVR);
    end else begin
      high_sel    = !rd.byte_sel;
      top_sel_ovr = rd.sign_sel;
    end
    if (high_sel) begin
      byte_d = {top_sel_ovr ? rd.overrange : rd.positive, rd.mag[14:8]};
    end else begin
      byte_d = rd.mag[7:0];
    end
  end

  // bus drive registered; released whenever the read is not active
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd.data <= 8'h00;
      rd.oe   <= 1'b0;
    end else begin
      rd.oe   <= rd.rd_active;
      rd.data <= rd.rd_active ? byte_d : 8'h00;
    end
  end
endmodule

// >>> hw/iabi_top.sv
`timescale 1ns/1ns
// converter control: clock divider, cycle sequencer, strobe handling, result latch
module iabi_top #(
  parameter int unsigned CLK_DIV = iabi_pkg::DIV_RATIO
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       chip_enable_n,
  input  wire logic       chip_select_hi,
  input  wire logic       read_strobe_n,
  input  wire logic       convert_strobe_n,
  input  wire logic       byte_select,
  input  wire logic       sign_over_select,
  input  wire logic       conversion_mode_select,
  input  wire logic       comparator_cross,
  input  wire logic       input_positive,
  output logic            busy,
  output logic            phase_zero,
  output logic            phase_integrate,
  output logic            phase_deintegrate,
  output logic      [7:0] data_out,
  output logic            data_oe
);
  localparam logic [7:0] DIV_LAST = 8'(CLK_DIV - 1);
  localparam logic [7:0] DIV_HALF = 8'(CLK_DIV / 2 - 1);

  if (CLK_DIV < 2 || CLK_DIV > 256 || (CLK_DIV % 2) != 0) begin : g_bad_div
    $error("CLK_DIV must be even and between 2 and 256");
  end

  iabi_rd_if rd ();

  logic [iabi_pkg::PIN_W-1:0] pins_s;
  logic                       wr_n_prev_q;
  logic                       rd_n_prev_q;
  logic                       selected;
  logic                       cont_mode;
  logic                       wr_fall;
  logic [7:0]                 div_q;
  logic                       tick;
  logic [10:0]                pos_q;
  logic                       running;
  logic                       pend_q;
  logic [10:0]                lock_q;
  logic                       start_now;
  iabi_pkg::iabi_sub_e        sub_q;
  logic [8:0]                 sub_cnt_q;
  logic [8:0]                 fast_q;
  logic [5:0]                 slow_q;
  logic [7:0]                 exc_q;
  logic                       ovr_q;
  logic                       pol_q;
  logic [14:0]                mag_q;
  logic                       res_pos_q;
  logic                       res_ovr_q;
  logic                       new_res_q;
  logic                       discard;

  // clamp the overrange excess to the reportable maximum
  function automatic logic [7:0] clamp_excess(input logic [7:0] count);
    return (count > iabi_pkg::EXCESS_CAP) ? iabi_pkg::EXCESS_CAP : count;
  endfunction

  // all bus and mode pins come from the host's timing, so synchronise them
  iabi_pin_sync #(
    .WIDTH (iabi_pkg::PIN_W),
    .INIT  (iabi_pkg::PIN_IDLE)
  ) u_pins (
    .clock    (clock),
    .rst      (rst),
    .async_in ({chip_enable_n, chip_select_hi, read_strobe_n, convert_strobe_n,
                byte_select, sign_over_select, conversion_mode_select}),
    .sync_out (pins_s)
  );

  // combined select gates both strobes
  assign selected  = !pins_s[iabi_pkg::PIN_CE_N] && pins_s[iabi_pkg::PIN_CS];
  assign cont_mode = pins_s[iabi_pkg::PIN_MODE];
  // falling edge only, so a strobe held low cannot retrigger
  assign wr_fall   = selected && wr_n_prev_q && !pins_s[iabi_pkg::PIN_WR_N];

  // strobe edge history
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_n_prev_q <= 1'b1;
      rd_n_prev_q <= 1'b1;
    end else begin
      wr_n_prev_q <= pins_s[iabi_pkg::PIN_WR_N];
      rd_n_prev_q <= pins_s[iabi_pkg::PIN_RD_N];
    end
  end

  // divide the oscillator down to the internal tick
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_q <= 8'h00;
    end else begin
      div_q <= (div_q == DIV_LAST) ? 8'h00 : 8'(div_q + 8'h01);
    end
  end
  assign tick = (div_q == DIV_LAST);

  // on-demand mode parks at the idle point until a start is pending
  assign start_now = tick && !cont_mode && pend_q && (pos_q == iabi_pkg::POS_IDLE);
  assign running   = cont_mode || (pos_q != iabi_pkg::POS_IDLE) || pend_q;

  // cycle position; wraps after exactly the full cycle length
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pos_q <= iabi_pkg::POS_IDLE;
    end else if (tick && running) begin
      pos_q <= (pos_q == iabi_pkg::POS_LAST) ? 11'h000 : 11'(pos_q + 11'h001);
    end
  end

  // pending start request; a new edge wins over the consuming start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (!cont_mode && wr_fall && lock_q == 11'h000) begin
      pend_q <= 1'b1;
    end else if (start_now || cont_mode) begin
      pend_q <= 1'b0;
    end
  end

  // strobe lockout counted in ticks from the accepted start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lock_q <= 11'h000;
    end else if (start_now) begin
      lock_q <= iabi_pkg::LOCKOUT_INIT;
    end else if (tick && lock_q != 11'h000) begin
      lock_q <= 11'(lock_q - 11'h001);
    end
  end

  // phase outputs for the analog switches, registered
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_zero        <= 1'b1;
      phase_integrate   <= 1'b0;
      phase_deintegrate <= 1'b0;
    end else begin
      phase_zero        <= (pos_q < iabi_pkg::POS_INTEG);
      phase_integrate   <= (pos_q >= iabi_pkg::POS_INTEG) && (pos_q < iabi_pkg::POS_DEINT);
      phase_deintegrate <= (pos_q >= iabi_pkg::POS_DEINT);
    end
  end

  // busy spans the last 836 ticks, so it falls exactly at the wrap
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (pos_q >= iabi_pkg::POS_BUSY_RISE);
    end
  end

  // polarity is known once signal integration ends
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pol_q <= 1'b0;
    end else if (tick && running && pos_q == 11'(iabi_pkg::POS_DEINT - 11'h001)) begin
      pol_q <= input_positive;
    end
  end

  // deintegrate subphases, each ended by the comparator crossing or by its count limit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sub_q     <= iabi_pkg::SP_IDLE;
      sub_cnt_q <= 9'h000;
      fast_q    <= 9'h000;
      slow_q    <= 6'h00;
      exc_q     <= 8'h00;
      ovr_q     <= 1'b0;
    end else if (tick && running) begin
      case (sub_q)
        iabi_pkg::SP_IDLE: begin
          if (pos_q == 11'(iabi_pkg::POS_DEINT - 11'h001)) begin
            sub_q     <= iabi_pkg::SP_FAST;
            sub_cnt_q <= 9'h000;
            fast_q    <= 9'h000;
            slow_q    <= 6'h00;
            exc_q     <= 8'h00;
            ovr_q     <= 1'b0;
          end
        end
        iabi_pkg::SP_FAST: begin
          if (comparator_cross) begin
            sub_q     <= iabi_pkg::SP_SLOW;
            fast_q    <= sub_cnt_q;
            sub_cnt_q <= 9'h000;
          end else if (sub_cnt_q == iabi_pkg::FAST_LAST) begin
            sub_q     <= iabi_pkg::SP_OVR; // beyond full scale
            ovr_q     <= 1'b1;
            sub_cnt_q <= 9'h000;
          end else begin
            sub_cnt_q <= 9'(sub_cnt_q + 9'h001);
          end
        end
        iabi_pkg::SP_SLOW: begin
          if (comparator_cross || sub_cnt_q[5:0] == iabi_pkg::SLOW_LAST) begin
            sub_q  <= iabi_pkg::SP_DONE;
            slow_q <= sub_cnt_q[5:0];
          end else begin
            sub_cnt_q <= 9'(sub_cnt_q + 9'h001);
          end
        end
        iabi_pkg::SP_OVR: begin
          if (comparator_cross || sub_cnt_q[7:0] == iabi_pkg::OVR_LAST) begin
            sub_q <= iabi_pkg::SP_DONE;
            exc_q <= sub_cnt_q[7:0];
          end else begin
            sub_cnt_q <= 9'(sub_cnt_q + 9'h001);
          end
        end
        iabi_pkg::SP_DONE: begin
          if (pos_q == iabi_pkg::POS_LAST) begin
            sub_q <= iabi_pkg::SP_IDLE;
          end
        end
        default: begin
          sub_q <= iabi_pkg::SP_IDLE;
        end
      endcase
    end
  end

  // continuous mode drops the result half a tick before busy rises again
  assign discard = cont_mode && (pos_q == iabi_pkg::POS_DISCARD) && (div_q == DIV_HALF);

  // result latch at the busy falling edge; held until next latch or discard
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mag_q     <= 15'h0000;
      res_pos_q <= 1'b0;
      res_ovr_q <= 1'b0;
      new_res_q <= 1'b0;
    end else begin
      new_res_q <= 1'b0;
      if (tick && running && pos_q == iabi_pkg::POS_LAST) begin
        new_res_q <= 1'b1;
        res_pos_q <= pol_q;
        res_ovr_q <= ovr_q;
        if (ovr_q) begin
          mag_q <= {7'h00, clamp_excess(exc_q)};
        end else begin
          mag_q <= {fast_q, slow_q};
        end
      end else if (discard) begin
        mag_q     <= 15'h0000;
        res_pos_q <= 1'b0;
        res_ovr_q <= 1'b0;
      end
      // on-demand results stay put through any number of reads
    end
  end

  // read path wiring
  assign rd.rd_active  = selected && !pins_s[iabi_pkg::PIN_RD_N];
  assign rd.rd_rise    = selected && !rd_n_prev_q && pins_s[iabi_pkg::PIN_RD_N];
  assign rd.cont_mode  = cont_mode;
  assign rd.byte_sel   = pins_s[iabi_pkg::PIN_BSEL];
  assign rd.sign_sel   = pins_s[iabi_pkg::PIN_SOSEL];
  assign rd.new_result = new_res_q;
  assign rd.discard    = discard;
  assign rd.mag        = mag_q;
  assign rd.positive   = res_pos_q;
  assign rd.overrange  = res_ovr_q;

  iabi_read_mux u_mux (
    .clock (clock),
    .rst   (rst),
    .rd    (rd.mux)
  );

  assign data_out = rd.data;
  assign data_oe  = rd.oe;
endmodule

// >>> tb/iabi_chk.sv
`timescale 1ns/1ns
// watches the top pins; run lengths are counted so every length up to 16'hffff clocks is exact
module iabi_chk #(
  parameter int unsigned CLK_DIV = 4
) (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       chip_enable_n,
  input wire logic       chip_select_hi,
  input wire logic       read_strobe_n,
  input wire logic       convert_strobe_n,
  input wire logic       byte_select,
  input wire logic       sign_over_select,
  input wire logic       conversion_mode_select,
  input wire logic       comparator_cross,
  input wire logic       input_positive,
  input wire logic       busy,
  input wire logic       phase_zero,
  input wire logic       phase_integrate,
  input wire logic       phase_deintegrate,
  input wire logic [7:0] data_out,
  input wire logic       data_oe
);
  localparam logic [15:0] BUSY_C = 16'(836 * CLK_DIV);
  localparam logic [15:0] GAP_C  = 16'(444 * CLK_DIV);
  localparam logic [15:0] INT_C  = 16'(256 * CLK_DIV);
  localparam logic [15:0] DEI_C  = 16'(778 * CLK_DIV);
  logic        sel_rd;
  logic [3:0]  idle_q;
  logic [2:0]  pv_q;
  logic [15:0] ph_q;
  logic        pb_q;
  logic [15:0] bc_q;
  logic        seen_q;
  logic [2:0]  ph;
  assign sel_rd = !chip_enable_n && chip_select_hi && !read_strobe_n;
  assign ph = {phase_zero, phase_integrate, phase_deintegrate};
  // clocks since the pins last asked for a read, saturating
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      idle_q <= 4'hf;
    end else if (sel_rd) begin
      idle_q <= 4'h0;
    end else if (idle_q != 4'hf) begin
      idle_q <= idle_q + 4'h1;
    end
  end
  // phase run length; saturates since the demand idle point can park forever
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pv_q <= 3'h4;
      ph_q <= 16'h0;
    end else begin
      pv_q <= ph;
      ph_q <= (ph != pv_q) ? 16'h1 : ((ph_q == 16'hffff) ? ph_q : ph_q + 16'h1);
    end
  end
  // busy run length; gap only judged after a fall seen in continuous mode
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pb_q   <= 1'b0;
      bc_q   <= 16'h0;
      seen_q <= 1'b0;
    end else begin
      pb_q   <= busy;
      bc_q   <= (busy != pb_q) ? 16'h1 : ((bc_q == 16'hffff) ? bc_q : bc_q + 16'h1);
      seen_q <= conversion_mode_select && (seen_q || (pb_q && !busy));
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_read_held;
    sel_rd [*8];
  endsequence
  sequence s_busy_end;
    $fell(busy);
  endsequence
  AST_OE_SEL: assert property (data_oe |-> idle_q < 4'h8)
    else $error("bus driven without read");
  AST_OE_ON: assert property (s_read_held |-> data_oe)
    else $error("bus not driven on read");
  AST_QUIET: assert property (!data_oe |-> data_out == 8'h00)
    else $error("data moves while released");
  AST_BUSY_LEN: assert property (s_busy_end |-> bc_q == BUSY_C)
    else $error("busy high time wrong");
  AST_BUSY_GAP: assert property ($rose(busy) && seen_q |-> bc_q == GAP_C)
    else $error("cycle length wrong");
  AST_INTEG: assert property ($rose(phase_deintegrate) |-> ph_q == INT_C)
    else $error("integrate length wrong");
  AST_DEINT: assert property ($fell(phase_deintegrate) |-> ph_q == DEI_C)
    else $error("deintegrate length wrong");
  AST_END: assert property (s_busy_end |-> ##[0:8] phase_zero)
    else $error("busy fell before cycle end");
endmodule

bind iabi_top iabi_chk #(.CLK_DIV(CLK_DIV)) i_iabi_chk (
  .clock(clock), .rst(rst), .chip_enable_n(chip_enable_n), .chip_select_hi(chip_select_hi),
  .read_strobe_n(read_strobe_n), .convert_strobe_n(convert_strobe_n), .byte_select(byte_select),
  .sign_over_select(sign_over_select), .conversion_mode_select(conversion_mode_select),
  .comparator_cross(comparator_cross), .input_positive(input_positive), .busy(busy),
  .phase_zero(phase_zero), .phase_integrate(phase_integrate), .phase_deintegrate(phase_deintegrate),
  .data_out(data_out), .data_oe(data_oe));

// >>> tb/iabi_host.sv
`timescale 1ns/1ns
// bus master: selects and strobes change on the falling edge only
module iabi_host (
  input  wire logic       clock,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic            chip_enable_n,
  output logic            chip_select_hi,
  output logic            read_strobe_n,
  output logic            convert_strobe_n,
  output logic            byte_select,
  output logic            sign_over_select,
  output logic            conversion_mode_select
);
  // idle: deselected, strobes released, on-demand
  initial begin
    chip_enable_n = 1'b1;
    chip_select_hi = 1'b0;
    read_strobe_n = 1'b1;
    convert_strobe_n = 1'b1;
    byte_select = 1'b0;
    sign_over_select = 1'b0;
    conversion_mode_select = 1'b0;
  end
  // one byte per strobe; selects may stay active between bytes
  task automatic rd_byte(input logic sel, input logic bs, input logic so,
                         output logic [7:0] d, output logic oe);
    int n;
    @(negedge clock);
    chip_enable_n = 1'b0;
    chip_select_hi = sel;
    byte_select = bs;
    sign_over_select = so;
    read_strobe_n = 1'b0;
    n = 0;
    while (data_oe !== 1'b1 && n < 12) begin
      @(negedge clock);
      n++;
    end
    oe = data_oe;
    d = data_out;
    read_strobe_n = 1'b1;
    repeat (10) @(negedge clock); // strobe gap long enough for the sync filter
  endtask
  // convert strobe of a given length, selected; bus contents play no part
  task automatic convert(input int hold);
    @(negedge clock);
    chip_enable_n = 1'b0;
    chip_select_hi = 1'b1;
    convert_strobe_n = 1'b0;
    repeat (hold) @(negedge clock);
    convert_strobe_n = 1'b1;
  endtask
endmodule

// >>> tb/tb_integrating_adc_bus_interface.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_integrating_adc_bus_interface;
  logic       clock, rst, comparator_cross, input_positive, busy, data_oe, got;
  logic       chip_enable_n, chip_select_hi, read_strobe_n, convert_strobe_n;
  logic       byte_select, sign_over_select, conversion_mode_select;
  logic       phase_zero, phase_integrate, phase_deintegrate;
  logic [7:0] data_out, d;
  int         fail_count, samples_checked, cyc, falls, t0, t1, ta;
  iabi_top i_iabi_top (
    .clock(clock), .rst(rst), .chip_enable_n(chip_enable_n), .chip_select_hi(chip_select_hi),
    .read_strobe_n(read_strobe_n), .convert_strobe_n(convert_strobe_n), .byte_select(byte_select),
    .sign_over_select(sign_over_select), .conversion_mode_select(conversion_mode_select),
    .comparator_cross(comparator_cross), .input_positive(input_positive), .busy(busy),
    .phase_zero(phase_zero), .phase_integrate(phase_integrate),
    .phase_deintegrate(phase_deintegrate), .data_out(data_out), .data_oe(data_oe));
  iabi_host i_iabi_host (
    .clock(clock), .data_out(data_out), .data_oe(data_oe), .chip_enable_n(chip_enable_n),
    .chip_select_hi(chip_select_hi), .read_strobe_n(read_strobe_n),
    .convert_strobe_n(convert_strobe_n), .byte_select(byte_select),
    .sign_over_select(sign_over_select), .conversion_mode_select(conversion_mode_select));
  // 10 MHz
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // hang guard, well above the planned run of about 45000 clocks
  always @(posedge clock) begin
    cyc++;
    if (cyc > 90000) begin
      fail_count++;
      $display("BAD run exp done got hang");
      tally_and_finish();
    end
  end
  // log of busy falls, ignoring the settle during reset
  always @(negedge busy) begin
    if (!rst) begin
      falls++;
      t1 = cyc;
    end
  end
  task automatic rd(input logic sel, input logic bs, input logic so);
    i_iabi_host.rd_byte(sel, bs, so, d, got);
  endtask
  task automatic wait_fall(input int lim);
    int f;
    int n;
    f = falls;
    n = 0;
    while (falls == f && n < lim) begin
      @(negedge clock);
      n++;
    end
    `CHK("busy fall", 1'b1, n < lim)
  endtask
  initial begin
    rst = 1'b1;
    comparator_cross = 1'b1;
    input_positive = 1'b1;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    repeat (10) @(negedge clock);
    // strobe held low: one conversion only, busy falls 1155 ticks on
    t0 = cyc;
    i_iabi_host.convert(12000);
    `CHK("conversions", 1, falls)
    `CHK("latency", 1'b1, (t1 - t0) >= 4612 && (t1 - t0) <= 4640)
    // immediate crossing: zero magnitude, positive; low byte read first
    rd(1'b1, 1'b1, 1'b0);
    `CHK("low byte", 8'h00, d)
    rd(1'b1, 1'b0, 1'b0);
    `CHK("high pol", 8'h80, d)
    rd(1'b1, 1'b0, 1'b1);
    `CHK("high ovr", 8'h00, d)
    rd(1'b0, 1'b0, 1'b0);
    `CHK("deselected oe", 1'b0, got)
    // no crossing: overrange with clamped excess; strobe in lockout dropped
    comparator_cross = 1'b0;
    input_positive = 1'b0;
    ta = falls;
    i_iabi_host.convert(4);
    repeat (1200) @(negedge clock);
    i_iabi_host.convert(4);
    repeat (10000) @(negedge clock);
    `CHK("lockout conversions", 1, falls - ta)
    rd(1'b1, 1'b1, 1'b1);
    `CHK("excess", 8'hbe, d)
    rd(1'b1, 1'b0, 1'b1);
    `CHK("ovr flag", 8'h80, d)
    rd(1'b1, 1'b0, 1'b0);
    `CHK("neg pol", 8'h00, d)
    // strobe past lockout is held: next busy fall a full cycle later
    i_iabi_host.convert(4);
    repeat (4480) @(negedge clock);
    i_iabi_host.convert(4);
    wait_fall(6000);
    ta = t1;
    wait_fall(6000);
    `CHK("back to back", 5120, t1 - ta)
    // continuous: byte selects ignored, internal counter orders the bytes
    input_positive = 1'b1;
    i_iabi_host.conversion_mode_select = 1'b1;
    wait_fall(6000);
    wait_fall(6000);
    rd(1'b1, 1'b1, 1'b1);
    `CHK("seq high pol", 8'h80, d)
    rd(1'b1, 1'b0, 1'b0);
    `CHK("seq low", 8'hbe, d)
    rd(1'b1, 1'b1, 1'b0);
    `CHK("seq high ovr", 8'h80, d)
    // past the valid window the result reads as cleared
    repeat (1800 - (cyc - t1)) @(negedge clock);
    rd(1'b1, 1'b0, 1'b0);
    `CHK("discarded", 8'h00, d)
    tally_and_finish();
  end
endmodule
